// File: alscr_pkg.sv
package alscr_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h84;
  localparam logic [7:0] ADDR_RES_HI = 8'h85;
  localparam logic [7:0] ADDR_RES_LO = 8'h86;
  localparam int CONT_BIT = 7;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 4;
  localparam int OFFS_BIT = 3;
  localparam int AVG_HI = 2;
  localparam int AVG_LO = 0;
  // cont 0, rate 000, offset on, average 101
  localparam logic [7:0] CONFIG_RESET = 8'h0D;
  localparam logic [7:0] CONFIG_MASK = 8'hFF;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CLK_HZ = 40000000;
  typedef enum {
    ALSCR_IDLE,
    ALSCR_OFFSET,
    ALSCR_CONVERT,
    ALSCR_STORE
  } alscr_state_type;
endpackage

// File: alscr_rate_timer.sv
`timescale 1ns/1ps
module alscr_rate_timer #(
  parameter int CLK_HZ = alscr_pkg::CLK_HZ
) (
  clk,
  srst,
  run,
  rateCode,
  tick
);
  input wire logic clk;
  input wire logic srst;
  input wire logic run;
  input wire logic [2:0] rateCode;
  output logic tick;

  // ---------------------------------------------
  // period per rate code, 1..10 samples/s
  // ---------------------------------------------
  logic [31:0] periodQ;
  logic [31:0] cntQ;

  always_comb begin
    case (rateCode)
      3'h0: periodQ = 32'(CLK_HZ / 1);
      3'h1: periodQ = 32'(CLK_HZ / 2);
      3'h2: periodQ = 32'(CLK_HZ / 3);
      3'h3: periodQ = 32'(CLK_HZ / 4);
      3'h4: periodQ = 32'(CLK_HZ / 5);
      3'h5: periodQ = 32'(CLK_HZ / 6);
      3'h6: periodQ = 32'(CLK_HZ / 8);
      default: periodQ = 32'(CLK_HZ / 10);
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cntQ <= 32'h00000000;
      tick <= 1'b0;
    end else if (cntQ >= periodQ - 32'h00000001) begin
      cntQ <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cntQ <= cntQ + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

// File: alscr_light_block.sv
`timescale 1ns/1ps
// Contract
// (RQ1) continuous bit enables back-to-back conversion, reset 0
// (RQ2) continuous mode repeats conversions back to back
// (RQ3) host uses continuous only with single-shot
// (RQ4) rate code selects 1..10 samples/s
// (RQ5) offset compensation bit, resets enabled
// (RQ6) measure offset, subtract before storing
// (RQ7) averaging field gives 2^n conversions
// (RQ8) result is average of cycle conversions
// (RQ9) averaging resets to 101, 32 conversions
// (RQ10) config change waits for periodic mode cycling
// (RQ11) result high at 85h, low 86h
// (RQ12) result registers read-only, writes ignored
// (RQ13) host changes rates only when idle
// (RQ14) both result bytes update together
module alscr_light_block #(
  parameter int CLK_HZ = alscr_pkg::CLK_HZ
) (
  clk,
  srst,
  regWrite,
  regRead,
  regAddr,
  regWdata,
  regRdata,
  regRvalid,
  periodicEn,
  lightSingleShot,
  convStart,
  convOffset,
  convDone,
  convValue,
  resultReady,
  busy
);
  input wire logic clk;
  input wire logic srst;
  input wire logic regWrite;
  input wire logic regRead;
  input wire logic [7:0] regAddr;
  input wire logic [7:0] regWdata;
  output logic [7:0] regRdata;
  output logic regRvalid;
  input wire logic periodicEn;
  input wire logic lightSingleShot;
  output logic convStart;
  output logic convOffset;
  input wire logic convDone;
  input wire logic [15:0] convValue;
  output logic resultReady;
  output logic busy;

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [2:0] syncAQ;
  logic [2:0] syncBQ;
  logic [15:0] valAQ;
  logic [15:0] valBQ;
  logic doneDlyQ;
  // control levels, two flops each
  always_ff @(posedge clk) begin
    if (srst) begin
      syncAQ <= 3'h0;
      syncBQ <= 3'h0;
      doneDlyQ <= 1'b0;
    end else begin
      syncAQ <= {periodicEn, lightSingleShot, convDone};
      syncBQ <= syncAQ;
      doneDlyQ <= syncBQ[0];
    end
  end

  // conversion value, steady while done stands
  always_ff @(posedge clk) begin
    if (srst) begin
      valAQ <= 16'h0000;
      valBQ <= 16'h0000;
    end else begin
      valAQ <= convValue;
      valBQ <= valAQ;
    end
  end
  logic perSync;
  logic shotSync;
  logic doneSync;
  logic doneRise;
  logic shotDlyQ;
  logic perDlyQ;
  assign perSync = syncBQ[2];
  assign shotSync = syncBQ[1];
  assign doneSync = syncBQ[0];
  assign doneRise = doneSync && !doneDlyQ;

  // ---------------------------------------------
  // configuration register
  // ---------------------------------------------
  logic [7:0] configQ;
  logic [7:0] activeQ;
  always_ff @(posedge clk) begin
    if (srst) begin
      configQ <= alscr_pkg::CONFIG_RESET; // [RQ1] [RQ5] [RQ9]
    end else if (regWrite && regAddr == alscr_pkg::ADDR_CONFIG) begin
      configQ <= regWdata & alscr_pkg::CONFIG_MASK;
    end
  end

  // working copy loaded only when periodic mode is off or just turned on
  always_ff @(posedge clk) begin
    if (srst) begin
      activeQ <= alscr_pkg::CONFIG_RESET;
      perDlyQ <= 1'b0;
    end else begin
      perDlyQ <= perSync;
      if (!perSync || !perDlyQ) begin
        activeQ <= configQ; // [RQ10]
      end
    end
  end

  logic contMode;
  logic offsEn;
  logic [2:0] avgCode;
  logic [2:0] rateCode;
  assign contMode = activeQ[alscr_pkg::CONT_BIT];
  assign offsEn = activeQ[alscr_pkg::OFFS_BIT];
  assign avgCode = activeQ[alscr_pkg::AVG_HI:alscr_pkg::AVG_LO];
  assign rateCode = activeQ[alscr_pkg::RATE_HI:alscr_pkg::RATE_LO];

  // ---------------------------------------------
  // periodic rate timer
  // ---------------------------------------------
  logic rateTick;
  alscr_rate_timer #(
    .CLK_HZ(CLK_HZ)
  ) uTimer (
    .clk(clk),
    .srst(srst),
    .run(perSync),
    .rateCode(rateCode),
    .tick(rateTick) // [RQ4]
  );

  // ---------------------------------------------
  // measurement sequencer
  // ---------------------------------------------
  alscr_pkg::alscr_state_type stateQ;
  logic [7:0] convLeftQ;
  logic [22:0] sumQ;
  logic [15:0] offsetQ;
  logic [15:0] resultQ;
  logic trigger;
  logic [15:0] corrected;
  logic [22:0] avgValue;
  logic idleGo;
  logic offsDone;
  logic convHit;
  logic lastConv;
  logic storeNow;

  always_ff @(posedge clk) begin
    if (srst) begin
      shotDlyQ <= 1'b0;
    end else begin
      shotDlyQ <= shotSync;
    end
  end
  // continuous mode retriggers at once after each store while single-shot is held and periodic mode is off
  assign trigger = rateTick || (shotSync && !shotDlyQ) ||
                   (contMode && !perSync && shotSync); // [RQ2] [RQ3]
  assign corrected = (offsEn && valBQ > offsetQ) ? valBQ - offsetQ :
                     (offsEn ? 16'h0000 : valBQ); // [RQ6]
  assign avgValue = sumQ >> avgCode; // [RQ8]
  // one-cycle qualifiers of the sequencer
  assign idleGo = (stateQ == alscr_pkg::ALSCR_IDLE) && trigger;
  assign offsDone = (stateQ == alscr_pkg::ALSCR_OFFSET) && doneRise;
  assign convHit = (stateQ == alscr_pkg::ALSCR_CONVERT) && doneRise;
  assign lastConv = convHit && (convLeftQ == 8'h01);
  assign storeNow = (stateQ == alscr_pkg::ALSCR_STORE);

  // state transitions
  always_ff @(posedge clk) begin
    if (srst) begin
      stateQ <= alscr_pkg::ALSCR_IDLE;
    end else begin
      case (stateQ)
        alscr_pkg::ALSCR_IDLE: begin
          if (trigger && offsEn) begin
            stateQ <= alscr_pkg::ALSCR_OFFSET; // [RQ6]
          end else if (trigger) begin
            stateQ <= alscr_pkg::ALSCR_CONVERT;
          end
        end
        alscr_pkg::ALSCR_OFFSET: begin
          if (doneRise) begin
            stateQ <= alscr_pkg::ALSCR_CONVERT;
          end
        end
        alscr_pkg::ALSCR_CONVERT: begin
          if (lastConv) begin
            stateQ <= alscr_pkg::ALSCR_STORE;
          end
        end
        alscr_pkg::ALSCR_STORE: begin
          stateQ <= alscr_pkg::ALSCR_IDLE;
        end
        default: begin
          stateQ <= alscr_pkg::ALSCR_IDLE;
        end
      endcase
    end
  end

  // conversion count and running sum
  always_ff @(posedge clk) begin
    if (srst) begin
      convLeftQ <= 8'h00;
      sumQ <= 23'h000000;
    end else if (idleGo) begin
      convLeftQ <= 8'(9'h001 << avgCode); // [RQ7]
      sumQ <= 23'h000000;
    end else if (convHit) begin
      convLeftQ <= convLeftQ - 8'h01;
      sumQ <= sumQ + {7'h00, corrected}; // [RQ8]
    end
  end

  // offset capture
  always_ff @(posedge clk) begin
    if (srst) begin
      offsetQ <= 16'h0000;
    end else if (idleGo && !offsEn) begin
      offsetQ <= 16'h0000;
    end else if (offsDone) begin
      offsetQ <= valBQ; // [RQ6]
    end
  end

  // result word, both bytes at once
  always_ff @(posedge clk) begin
    if (srst) begin
      resultQ <= alscr_pkg::RESULT_RESET;
      resultReady <= 1'b0;
    end else begin
      resultReady <= storeNow;
      if (storeNow) begin
        resultQ <= avgValue[15:0]; // [RQ14]
      end
    end
  end

  // front end strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      convStart <= 1'b0;
      convOffset <= 1'b0;
    end else begin
      convStart <= idleGo || offsDone || (convHit && !lastConv);
      if (idleGo) begin
        convOffset <= offsEn; // [RQ6]
      end else if (offsDone) begin
        convOffset <= 1'b0;
      end
    end
  end

  // busy from trigger to the return to idle
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else if (stateQ == alscr_pkg::ALSCR_IDLE) begin
      busy <= trigger;
    end
  end

  // ---------------------------------------------
  // register read port
  // ---------------------------------------------
  // read strobe answer
  always_ff @(posedge clk) begin
    if (srst) begin
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
    end
  end

  // read data mux, held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= alscr_pkg::READ_UNMAPPED;
    end else if (regRead) begin
      case (regAddr)
        alscr_pkg::ADDR_CONFIG: regRdata <= configQ;
        alscr_pkg::ADDR_RES_HI: regRdata <= resultQ[15:8]; // [RQ11] [RQ12]
        alscr_pkg::ADDR_RES_LO: regRdata <= resultQ[7:0]; // [RQ11] [RQ12]
        default: regRdata <= alscr_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // host rate changes while active are held off by the working copy [RQ13]
endmodule

// File: alscr_light_block_properties.sv
`timescale 1ns/1ps
module alscr_light_block_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  input wire logic periodicEn,
  input wire logic convStart,
  input wire logic convOffset,
  input wire logic resultReady,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  read_valid_a: assert property (regRead |=> regRvalid) else $error("no rvalid");
  valid_cause_a: assert property (regRvalid |-> $past(regRead)) else $error("rvalid");
  cfg_readback_a: assert property (regWrite && regAddr == 8'h84 && !periodicEn ##2
    regRead && regAddr == 8'h84 |=> regRdata == $past(regWdata, 3)) else $error("cfg");
  unmapped_read_a: assert property (regRead && (regAddr < 8'h84 || regAddr > 8'h86)
    |=> regRdata == 8'h00) else $error("unmapped");
  start_pulse_a: assert property (convStart |=> !convStart) else $error("start");
  offset_first_a: assert property ($rose(convOffset) |-> convStart) else $error("offs");
  ready_pulse_a: assert property (resultReady |=> !resultReady) else $error("ready");
  start_busy_a: assert property (convStart |-> busy) else $error("busy");
  ready_cause_a: assert property (resultReady |-> $past(busy)) else $error("cause");
endmodule
bind alscr_light_block alscr_light_block_properties CHK (.clk(clk), .srst(srst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .regRvalid(regRvalid), .periodicEn(periodicEn),
  .convStart(convStart), .convOffset(convOffset), .resultReady(resultReady), .busy(busy));

// File: alscr_front_end.sv
`timescale 1ns/1ps
module alscr_front_end (
  input wire logic clk,
  input wire logic slow,
  input wire logic convStart,
  input wire logic convOffset,
  input wire logic [15:0] offsetVal,
  input wire logic [15:0] sampleVal,
  output logic convDone,
  output logic [15:0] convValue
);
  logic [3:0] cnt_q = 4'h0;
  logic isOff_q = 1'b0;
  logic [15:0] val;
  always_ff @(posedge clk) begin
    if (convStart) begin
      cnt_q <= slow ? 4'hC : 4'h5;
      isOff_q <= convOffset;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // offset and light readings differ
  assign val = isOff_q ? offsetVal : sampleVal;
  assign convDone = cnt_q != 4'h0 && cnt_q < 4'h4;
  assign convValue = cnt_q != 4'h0 ? val : ~val;
endmodule

// File: test_ambient_light_config_and_result.sv
`timescale 1ns/1ps
module test_ambient_light_config_and_result;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic periodicEn = 1'b0;
  logic lightSingleShot = 1'b0;
  logic slow = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [15:0] offsetVal = 16'h0000;
  logic [15:0] sampleVal = 16'h0000;
  logic [7:0] starts = 8'h00;
  logic [7:0] lastStarts = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] cfg;
  logic [15:0] convValue;
  logic [15:0] expVal;
  logic regRvalid, convStart, convOffset, convDone, resultReady, busy;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 16;
  int cycles = 0;
  int t;
  always #12.5 clk = ~clk;
  alscr_light_block #(.CLK_HZ(100)) DUT (.clk(clk), .srst(srst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .periodicEn(periodicEn), .lightSingleShot(lightSingleShot),
    .convStart(convStart), .convOffset(convOffset), .convDone(convDone),
    .convValue(convValue), .resultReady(resultReady), .busy(busy));
  alscr_front_end FE (.clk(clk), .slow(slow), .convStart(convStart), .convOffset(convOffset),
    .offsetVal(offsetVal), .sampleVal(sampleVal), .convDone(convDone), .convValue(convValue));
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (resultReady === 1'b1) begin
      lastStarts <= starts;
      starts <= 8'h00;
    end else if (convStart === 1'b1) begin
      starts <= starts + 8'h01;
    end
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    check({7'h00, regRvalid, regRdata}, {8'h01, e});
  endtask
  task automatic wait_ready();
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (resultReady !== 1'b1);
    @(posedge clk);
  endtask
  function automatic logic [15:0] expect_res(logic [7:0] c, logic [15:0] s, logic [15:0] o);
    if (!c[3]) return s;
    return (o > s) ? 16'h0000 : s - o;
  endfunction
  task automatic res_check(logic [7:0] c);
    expVal = expect_res(c, sampleVal, offsetVal);
    rdc(8'h85, expVal[15:8]);
    rdc(8'h86, expVal[7:0]);
    check({8'h00, lastStarts}, (16'h0001 << c[2:0]) + {15'h0000, c[3]});
  endtask
  task automatic meas(logic [7:0] c);
    wr(8'h84, c);
    rdc(8'h84, c);
    sampleVal <= 16'($random(seed));
    offsetVal <= 16'($random(seed)) >> 1;
    slow <= 1'($random(seed));
    lightSingleShot <= 1'b1;
    wait_ready();
    lightSingleShot <= c[7];
    res_check(c);
    $display("measurement cfg %h done", c);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rdc(8'h84, 8'h0D);
    wr(8'h85, 8'hFF);
    wr(8'h86, 8'hFF);
    rdc(8'h85, 8'h00);
    rdc(8'h86, 8'h00);
    rdc(8'h87, 8'h00);
    $display("register test done");
    for (int k = 0; k < 12; k++) begin
      cfg = (k == 0) ? 8'h07 : (k == 1) ? 8'h08 : 8'($random(seed)) & 8'h7F;
      meas(cfg);
    end
    meas(8'h8C);
    wait_ready();
    res_check(8'h8C);
    lightSingleShot <= 1'b0;
    do @(negedge clk); while (busy !== 1'b0);
    @(posedge clk);
    slow <= 1'b0;
    wr(8'h84, 8'h08);
    periodicEn <= 1'b1;
    wait_ready();
    wr(8'h84, 8'h39);
    wait_ready();
    check(16'(t >= 90 && t <= 110), 16'h0001);
    res_check(8'h08);
    periodicEn <= 1'b0;
    repeat (4) @(posedge clk);
    periodicEn <= 1'b1;
    wait_ready();
    wait_ready();
    check(16'(t >= 20 && t <= 30), 16'h0001);
    res_check(8'h39);
    periodicEn <= 1'b0;
    $display("periodic test done");
    close_out();
  end
endmodule
